// [pkg/gmc_regs.svh]
`ifndef GMC_REGS_SVH
`define GMC_REGS_SVH
// Behaviour
// - SC byte: six C/I, MR bit1, MX bit0
// - Both handshake bits high two frames: idle
// - Capture byte, drive MR low next frame
// - Write uses host MX; read uses device MX
// - Silent side sends all-ones Monitor byte
// - Non-FF downstream while sending: abort
// - Working address increments after every access
// - Abort holds MR high until host idle, two frames at least
// - Invalid command or early end: no change
// - Byte accepted after two equal copies
// - MX released before match: abort
// - Address byte fixed bits; C selects identify
// - Identify: zero command, two-byte code, end
// - A selects voice channel; A0 B1 aborts
// - A, B enable channels for command
// - Read answer starts with address byte
// - Top bit read/write; field 1 register access
// - Primary C/I kept; differing bits to secondary
// - Secondary confirmed next frame or discarded
// - Four bytes per sub-frame, frame sync start
// - Transmit slot bytes most significant first

// Sub-frame layout in bit times
`define GMC_SLOT_BITS 32
`define GMC_OFF_M 5'h10
`define GMC_OFF_SC 5'h18
`define GMC_OFF_LAST 5'h1f
`define GMC_M_HI 2'h2
`define GMC_SC_HI 2'h3
`define GMC_TX_LEAD 8'h03
// Byte codes
`define GMC_IDLE_BYTE 8'hff
`define GMC_CID_CMD 8'h00
`define GMC_CMD_REG 7'h01
`define GMC_ADDR_FIX 3'h4
`define GMC_BIT_A 4
`define GMC_BIT_B 3
`define GMC_BIT_C 0
// Frame counts
`define GMC_IDLE_FRAMES 2'h2
`define GMC_ABORT_FRAMES 3'h2
`define GMC_RX_LIMIT 3'h4
`define GMC_ACK_LIMIT 3'h6
`define GMC_FCNT_MAX 3'h7
`endif

// [pkg/gmc_pkg.sv]
package gmc_pkg;

  // One frame's view of the own sub-frame: Monitor byte plus SC byte
  typedef struct packed {
    logic [7:0] m;
    logic [5:0] ci;
    logic mr;
    logic mx;
  } gmc_frame_t;

  typedef enum logic [3:0] {
    GMC_IDLE   = 4'h0,
    GMC_RXWAIT = 4'h1,
    GMC_RXACK  = 4'h3,
    GMC_RXGAP  = 4'h2,
    GMC_TXSEND = 4'h6,
    GMC_TXGAP  = 4'h7,
    GMC_TXEOM1 = 4'h5,
    GMC_TXEOM2 = 4'h4,
    GMC_ABORT  = 4'hc,
    GMC_IGNORE = 4'hd
  } gmc_state_t;

endpackage

// [rtl/gmc_monitor.sv]
`timescale 1ns/10ps
`include "gmc_regs.svh"

module gmc_monitor #(
  // Identification code values are arbitrary
  parameter logic [7:0] CID_CODE0 = 8'h5a,
  parameter logic [7:0] CID_CODE1 = 8'ha5
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_link_clk,
  input wire logic i_fsync,
  input wire logic i_highway_receive_line,
  output logic o_highway_transmit_line,
  output logic o_highway_transmit_oe,
  input wire logic [2:0] i_subframe_sel,
  input wire logic i_voice_ch,
  input wire logic [5:0] i_ci_tx,
  output logic [5:0] o_ci_state,
  output logic o_ci_change,
  output logic [7:0] o_reg_addr,
  output logic [7:0] o_reg_wdata,
  output logic o_reg_wr,
  output logic o_reg_rd,
  input wire logic [7:0] i_reg_rdata,
  input wire logic i_reg_addr_ok,
  output logic o_abort_indication,
  output logic o_end_of_message,
  output logic o_link_idle,
  output logic o_busy
);

  // ==========================================================
  // Helpers
  function automatic logic pick_bit(input logic [7:0] b,
                                    input logic [2:0] off);
    pick_bit = b[3'h7 - off];
  endfunction

  function automatic logic [2:0] sat_inc(input logic [2:0] v);
    sat_inc = (v == `GMC_FCNT_MAX) ? v : v + 3'h1;
  endfunction

  // ==========================================================
  // Link domain: reset release, pin sampling, slot framing
  logic lrst1, lrst2;
  logic fs1, fs2, fs3, rx1, rx2;
  logic [2:0] sel1, sel2;
  logic [7:0] bit_cnt;
  logic [7:0] m_sh, sc_sh;
  gmc_pkg::gmc_frame_t rx_hold;
  logic rx_tog;
  logic tt1, tt2, tt3;
  gmc_pkg::gmc_frame_t ltx;
  logic [7:0] bit_idx, tx_pos, sc_full;

  always_ff @(posedge i_link_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      lrst1 <= 1'b0;
      lrst2 <= 1'b0;
    end else begin
      lrst1 <= 1'b1;
      lrst2 <= lrst1;
    end
  end

  always_ff @(posedge i_link_clk or negedge lrst2) begin
    if (!lrst2) begin
      fs1 <= 1'b0;
      fs2 <= 1'b0;
      fs3 <= 1'b0;
      rx1 <= 1'b1;
      rx2 <= 1'b1;
      sel1 <= 3'h0;
      sel2 <= 3'h0;
    end else begin
      fs1 <= i_fsync;
      fs2 <= fs1;
      fs3 <= fs2;
      rx1 <= i_highway_receive_line;
      rx2 <= rx1;
      sel1 <= i_subframe_sel;
      sel2 <= sel1;
    end
  end

  // Rising frame sync marks bit 0 of the frame
  assign bit_idx = (fs2 & ~fs3) ? 8'h00 : bit_cnt;
  assign tx_pos = bit_idx + `GMC_TX_LEAD;
  assign sc_full = {sc_sh[6:0], rx2};

  always_ff @(posedge i_link_clk or negedge lrst2) begin
    if (!lrst2) begin
      bit_cnt <= 8'h00;
      m_sh <= `GMC_IDLE_BYTE;
      sc_sh <= `GMC_IDLE_BYTE;
      rx_hold <= '1;
      rx_tog <= 1'b0;
    end else begin
      bit_cnt <= bit_idx + 8'h01;
      if (bit_idx[7:5] == sel2) begin
        if (bit_idx[4:3] == `GMC_M_HI) begin
          m_sh <= {m_sh[6:0], rx2};
        end
        if (bit_idx[4:3] == `GMC_SC_HI) begin
          sc_sh <= sc_full;
        end
        // Whole word published once per frame; core reads it later
        if (bit_idx[4:0] == `GMC_OFF_LAST) begin
          rx_hold <= {m_sh, sc_full};
          rx_tog <= ~rx_tog;
        end
      end
    end
  end

  // ==========================================================
  // Link domain: upstream word pick-up and serialiser
  gmc_pkg::gmc_frame_t core_tx;
  logic tx_tog;

  always_ff @(posedge i_link_clk or negedge lrst2) begin
    if (!lrst2) begin
      tt1 <= 1'b0;
      tt2 <= 1'b0;
      tt3 <= 1'b0;
      ltx <= '1;
      o_highway_transmit_line <= 1'b1;
      o_highway_transmit_oe <= 1'b0;
    end else begin
      tt1 <= tx_tog;
      tt2 <= tt1;
      tt3 <= tt2;
      // Core word is held a whole frame, so copying on the toggle is safe
      if (tt2 ^ tt3) begin
        ltx <= core_tx;
      end
      o_highway_transmit_line <= 1'b1;
      o_highway_transmit_oe <= 1'b0;
      if (tx_pos[7:5] == sel2) begin
        if (tx_pos[4:3] == `GMC_M_HI) begin
          o_highway_transmit_line <= pick_bit(ltx.m, tx_pos[2:0]);
          o_highway_transmit_oe <= 1'b1;
        end
        if (tx_pos[4:3] == `GMC_SC_HI) begin
          o_highway_transmit_line <=
            pick_bit({ltx.ci, ltx.mr, ltx.mx}, tx_pos[2:0]);
          o_highway_transmit_oe <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Core domain: frame tick crossing
  logic rt1, rt2, rt3, tick, tick_d;
  gmc_pkg::gmc_frame_t f;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rt1 <= 1'b0;
      rt2 <= 1'b0;
      rt3 <= 1'b0;
      tick_d <= 1'b0;
    end else begin
      rt1 <= rx_tog;
      rt2 <= rt1;
      rt3 <= rt2;
      tick_d <= tick;
    end
  end

  assign tick = rt2 ^ rt3;
  assign f = rx_hold;

  // ==========================================================
  // Core domain: C/I validation
  logic [5:0] ci_s;
  logic ci_s_full;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_ci_state <= '1;
      ci_s <= '1;
      ci_s_full <= 1'b0;
      o_ci_change <= 1'b0;
    end else begin
      o_ci_change <= 1'b0;
      if (tick) begin
        if (f.ci == o_ci_state) begin
          ci_s_full <= 1'b0;
        end else if (ci_s_full && f.ci == ci_s) begin
          o_ci_state <= ci_s;
          o_ci_change <= 1'b1;
          ci_s_full <= 1'b0;
        end else begin
          ci_s <= f.ci;
          ci_s_full <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Core domain: link idle detection
  logic [1:0] idle_cnt;

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      idle_cnt <= 2'h0;
      o_link_idle <= 1'b0;
    end else if (tick) begin
      if (f.mx && f.mr) begin
        if (idle_cnt != `GMC_IDLE_FRAMES) begin
          idle_cnt <= idle_cnt + 2'h1;
        end
        o_link_idle <= (idle_cnt + 2'h1) >= `GMC_IDLE_FRAMES;
      end else begin
        idle_cnt <= 2'h0;
        o_link_idle <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Core domain: Monitor engine
  gmc_pkg::gmc_state_t state;
  logic [2:0] fcnt;
  logic [7:0] ll, dev_byte, tx_byte;
  logic [1:0] idx;
  logic cid_mode, cid_ok, cmd_ok, rw, tx_idx, hi_seen;
  logic fixed_ok, targeted;

  assign fixed_ok = (f.m[7:5] == `GMC_ADDR_FIX) && (f.m[2:1] == 2'h0);
  assign targeted = i_voice_ch ? f.m[`GMC_BIT_B] : f.m[`GMC_BIT_A];

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= gmc_pkg::GMC_IDLE;
      fcnt <= 3'h0;
      ll <= `GMC_IDLE_BYTE;
      dev_byte <= 8'h00;
      tx_byte <= `GMC_IDLE_BYTE;
      idx <= 2'h0;
      cid_mode <= 1'b0;
      cid_ok <= 1'b0;
      cmd_ok <= 1'b0;
      rw <= 1'b0;
      tx_idx <= 1'b0;
      hi_seen <= 1'b0;
      o_reg_addr <= 8'h00;
      o_reg_wdata <= 8'h00;
      o_reg_wr <= 1'b0;
      o_reg_rd <= 1'b0;
      o_abort_indication <= 1'b0;
      o_end_of_message <= 1'b0;
    end else begin
      o_reg_wr <= 1'b0;
      o_reg_rd <= 1'b0;
      o_abort_indication <= 1'b0;
      o_end_of_message <= 1'b0;
      if (o_reg_wr || o_reg_rd) begin
        o_reg_addr <= o_reg_addr + 8'h01;
      end
      if (tick) begin
        ll <= f.m;
        fcnt <= sat_inc(fcnt);
        case (state)
          gmc_pkg::GMC_IDLE: begin
            if (!f.mx) begin
              state <= gmc_pkg::GMC_RXWAIT;
              idx <= 2'h0;
              cid_mode <= 1'b0;
              cid_ok <= 1'b0;
              cmd_ok <= 1'b0;
              fcnt <= 3'h0;
            end
          end
          gmc_pkg::GMC_RXWAIT: begin
            if (f.mx) begin
              state <= gmc_pkg::GMC_ABORT;
              o_abort_indication <= 1'b1;
              fcnt <= 3'h0;
            end else if (f.m == ll) begin
              // Two equal copies: take the byte and acknowledge
              state <= gmc_pkg::GMC_RXACK;
              fcnt <= 3'h0;
              if (idx != 2'h3) begin
                idx <= idx + 2'h1;
              end
              case (idx)
                2'h0: begin
                  dev_byte <= f.m;
                  if (!fixed_ok) begin
                    state <= gmc_pkg::GMC_ABORT;
                    o_abort_indication <= 1'b1;
                  end else if (!f.m[`GMC_BIT_C]) begin
                    cid_mode <= 1'b1;
                    if (!f.m[`GMC_BIT_A] && f.m[`GMC_BIT_B]) begin
                      state <= gmc_pkg::GMC_ABORT;
                      o_abort_indication <= 1'b1;
                    end else if (f.m[`GMC_BIT_A] != i_voice_ch) begin
                      state <= gmc_pkg::GMC_IGNORE;
                    end
                  end else if (!targeted) begin
                    state <= gmc_pkg::GMC_IGNORE;
                  end
                end
                2'h1: begin
                  if (cid_mode) begin
                    if (f.m != `GMC_CID_CMD) begin
                      state <= gmc_pkg::GMC_ABORT;
                      o_abort_indication <= 1'b1;
                    end else begin
                      cid_ok <= 1'b1;
                    end
                  end else if (f.m[6:0] != `GMC_CMD_REG) begin
                    state <= gmc_pkg::GMC_ABORT;
                    o_abort_indication <= 1'b1;
                  end else begin
                    rw <= f.m[7];
                  end
                end
                2'h2: begin
                  if (cid_mode) begin
                    state <= gmc_pkg::GMC_ABORT;
                    o_abort_indication <= 1'b1;
                  end else begin
                    o_reg_addr <= f.m;
                    cmd_ok <= 1'b1;
                  end
                end
                default: begin
                  if (cid_mode || rw || !i_reg_addr_ok) begin
                    // Earlier writes of the sequence stay in place
                    state <= gmc_pkg::GMC_ABORT;
                    o_abort_indication <= 1'b1;
                  end else begin
                    o_reg_wdata <= f.m;
                    o_reg_wr <= 1'b1;
                  end
                end
              endcase
            end
          end
          gmc_pkg::GMC_RXACK: begin
            if (f.mx) begin
              state <= gmc_pkg::GMC_RXGAP;
            end else if (fcnt >= `GMC_RX_LIMIT) begin
              state <= gmc_pkg::GMC_ABORT;
              o_abort_indication <= 1'b1;
              fcnt <= 3'h0;
            end
          end
          gmc_pkg::GMC_RXGAP: begin
            fcnt <= 3'h0;
            if (!f.mx) begin
              state <= gmc_pkg::GMC_RXWAIT;
            end else begin
              o_end_of_message <= 1'b1;
              hi_seen <= 1'b0;
              tx_idx <= 1'b0;
              if (cid_ok) begin
                state <= gmc_pkg::GMC_TXSEND;
                tx_byte <= {CID_CODE0[7:5], dev_byte[`GMC_BIT_A],
                            CID_CODE0[3:0]};
              end else if (cmd_ok && rw) begin
                state <= gmc_pkg::GMC_TXSEND;
                tx_byte <= dev_byte;
              end else begin
                state <= gmc_pkg::GMC_IDLE;
              end
            end
          end
          gmc_pkg::GMC_TXSEND: begin
            if (f.mr) begin
              hi_seen <= 1'b1;
            end
            if (f.m != `GMC_IDLE_BYTE) begin
              state <= gmc_pkg::GMC_ABORT;
              o_abort_indication <= 1'b1;
              fcnt <= 3'h0;
            end else if (hi_seen && !f.mr) begin
              state <= gmc_pkg::GMC_TXGAP;
            end else if (fcnt >= `GMC_ACK_LIMIT) begin
              state <= gmc_pkg::GMC_TXEOM1;
            end
          end
          gmc_pkg::GMC_TXGAP: begin
            tx_idx <= 1'b1;
            hi_seen <= 1'b0;
            fcnt <= 3'h0;
            if (cid_ok) begin
              if (tx_idx) begin
                state <= gmc_pkg::GMC_TXEOM1;
              end else begin
                tx_byte <= CID_CODE1;
                state <= gmc_pkg::GMC_TXSEND;
              end
            end else if (!i_reg_addr_ok) begin
              state <= gmc_pkg::GMC_ABORT;
              o_abort_indication <= 1'b1;
            end else begin
              tx_byte <= i_reg_rdata;
              o_reg_rd <= 1'b1;
              state <= gmc_pkg::GMC_TXSEND;
            end
          end
          gmc_pkg::GMC_TXEOM1: begin
            state <= gmc_pkg::GMC_TXEOM2;
          end
          gmc_pkg::GMC_TXEOM2: begin
            state <= gmc_pkg::GMC_IDLE;
          end
          gmc_pkg::GMC_ABORT: begin
            // MR held high until host goes idle, two frames at least
            if (idle_cnt == `GMC_IDLE_FRAMES &&
                fcnt >= `GMC_ABORT_FRAMES) begin
              state <= gmc_pkg::GMC_IDLE;
            end
          end
          gmc_pkg::GMC_IGNORE: begin
            if (idle_cnt == `GMC_IDLE_FRAMES) begin
              state <= gmc_pkg::GMC_IDLE;
            end
          end
          default: begin
            state <= gmc_pkg::GMC_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Core domain: upstream word and busy flag
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      core_tx <= '1;
      tx_tog <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_busy <= state != gmc_pkg::GMC_IDLE;
      if (tick_d) begin
        core_tx.ci <= i_ci_tx;
        core_tx.mr <= ~(state == gmc_pkg::GMC_RXACK ||
                        state == gmc_pkg::GMC_RXGAP);
        core_tx.mx <= state != gmc_pkg::GMC_TXSEND;
        core_tx.m <= (state == gmc_pkg::GMC_TXSEND) ?
                     tx_byte : `GMC_IDLE_BYTE;
        tx_tog <= ~tx_tog;
      end
    end
  end

endmodule

// [test/gmc_monitor_sva.sv]
`timescale 1ns/10ps
module gmc_monitor_sva (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_link_clk,
  input wire logic o_highway_transmit_line,
  input wire logic o_highway_transmit_oe,
  input wire logic [5:0] o_ci_state,
  input wire logic o_ci_change,
  input wire logic [7:0] o_reg_addr,
  input wire logic o_reg_wr,
  input wire logic o_reg_rd,
  input wire logic i_reg_addr_ok,
  input wire logic o_abort_indication,
  input wire logic o_end_of_message,
  input wire logic o_busy
);
  // ==========================================
  // Register side, core clock
  sequence s_access;
    o_reg_wr || o_reg_rd;
  endsequence
  sequence s_quiet;
    !(o_reg_wr || o_reg_rd) [*8];
  endsequence
  property p_addr_inc;
    @(posedge i_core_clk) disable iff (!i_nrst)
    s_access |=> o_reg_addr == $past(o_reg_addr) + 8'h01;
  endproperty
  a_addr_inc: assert property (p_addr_inc)
    else $error("address did not step after access");
  property p_one_acc;
    @(posedge i_core_clk) disable iff (!i_nrst) s_access |=> s_quiet;
  endproperty
  a_one_acc: assert property (p_one_acc)
    else $error("accesses too close together");
  property p_wr_ok;
    @(posedge i_core_clk) disable iff (!i_nrst) s_access |-> i_reg_addr_ok;
  endproperty
  a_wr_ok: assert property (p_wr_ok)
    else $error("access at invalid address");
  property p_ab_pulse;
    @(posedge i_core_clk) disable iff (!i_nrst)
    o_abort_indication |=> !o_abort_indication;
  endproperty
  a_ab_pulse: assert property (p_ab_pulse)
    else $error("abort pulse too long");
  property p_ab_nowr;
    @(posedge i_core_clk) disable iff (!i_nrst)
    o_abort_indication |-> !o_reg_wr && !o_end_of_message;
  endproperty
  a_ab_nowr: assert property (p_ab_nowr)
    else $error("write or end alongside abort");
  property p_eom_idle;
    @(posedge i_core_clk) disable iff (!i_nrst)
    o_end_of_message |->
      o_busy ##1 (!o_reg_wr && !o_abort_indication) [*8];
  endproperty
  a_eom_idle: assert property (p_eom_idle)
    else $error("write or abort right after end of message");
  property p_ci_upd;
    @(posedge i_core_clk) disable iff (!i_nrst)
    $changed(o_ci_state) |-> o_ci_change || $past(o_ci_change);
  endproperty
  a_ci_upd: assert property (p_ci_upd)
    else $error("primary changed without pulse");
  property p_ci_pulse;
    @(posedge i_core_clk) disable iff (!i_nrst) o_ci_change |=> !o_ci_change;
  endproperty
  a_ci_pulse: assert property (p_ci_pulse)
    else $error("change pulse too long");
  // ==========================================
  // Highway side, link clock
  property p_line_idle;
    @(posedge i_link_clk) disable iff (!i_nrst)
    !o_highway_transmit_oe |-> o_highway_transmit_line;
  endproperty
  a_line_idle: assert property (p_line_idle)
    else $error("line not high while released");
  property p_oe_len;
    @(posedge i_link_clk) disable iff (!i_nrst)
    $rose(o_highway_transmit_oe) |-> o_highway_transmit_oe [*8];
  endproperty
  a_oe_len: assert property (p_oe_len)
    else $error("drive window too short");
endmodule

// [test/gmc_host_model.sv]
`timescale 1ns/10ps
module gmc_host_model (
  input wire logic i_link_clk,
  input wire logic i_nrst,
  input wire logic i_tx_line,
  input wire gmc_pkg::gmc_frame_t i_down,
  output logic o_fsync,
  output logic o_rx_line,
  output gmc_pkg::gmc_frame_t o_up,
  output logic [15:0] o_frames
);
  logic [7:0] pos;
  logic [7:0] nxt;
  logic [15:0] sh;
  assign nxt = pos + 8'h01;
  // ==========================================
  // Downstream, sub-frame 0, M then SC
  always_ff @(posedge i_link_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pos <= 8'h00;
      o_fsync <= 1'b0;
      o_rx_line <= 1'b1;
    end else begin
      pos <= nxt;
      o_fsync <= (nxt == 8'h00);
      // Foreign slots toggle so stale bits never look valid
      if (nxt[7:4] == 4'h1) begin
        o_rx_line <= i_down[~nxt[3:0]];
      end else begin
        o_rx_line <= nxt[0];
      end
    end
  end
  // ==========================================
  // Upstream capture, mid-bit
  always_ff @(negedge i_link_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sh <= 16'hffff;
      o_up <= 16'hffff;
      o_frames <= 16'h0000;
    end else begin
      if (pos[7:4] == 4'h1) begin
        sh[~pos[3:0]] <= i_tx_line;
      end
      if (pos == 8'h20) begin
        o_up <= sh;
        o_frames <= o_frames + 16'h0001;
      end
    end
  end
endmodule

// [test/tb_gmc_monitor.sv]
`timescale 1ns/10ps
module tb_gmc_monitor;
  logic core_clk, link_clk, nrst, fsync, rxl, txl, oe, chg, wr, rd;
  logic ab, end_of_message, lidle, busy, aok;
  logic [5:0] ci_st, ci_dn;
  logic [7:0] addr, wdata, rdata, v;
  logic [15:0] frames;
  gmc_pkg::gmc_frame_t down, up;
  int bad_count, checks_done, ab_n, eom_n, cic_n, rd_n, k;
  logic [15:0] wq[$];
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #7.5 link_clk = ~link_clk;
  end
  // Register file stand-in, valid below 8'h20
  assign rdata = addr ^ 8'h5a;
  assign aok = addr < 8'h20;
  always @(posedge core_clk) begin
    if (wr === 1'b1) wq.push_back({addr, wdata});
    if (ab === 1'b1) ab_n++;
    if (end_of_message === 1'b1) eom_n++;
    if (chg === 1'b1) cic_n++;
    if (rd === 1'b1) rd_n++;
  end
  gmc_monitor #(.CID_CODE0(8'h5a), .CID_CODE1(8'ha5)) u_gmc_monitor (
    .i_core_clk(core_clk), .i_nrst(nrst),
    .i_link_clk(link_clk), .i_fsync(fsync), .i_highway_receive_line(rxl),
    .o_highway_transmit_line(txl), .o_highway_transmit_oe(oe),
    .i_subframe_sel(3'h0), .i_voice_ch(1'b0), .i_ci_tx(6'h15),
    .o_ci_state(ci_st), .o_ci_change(chg), .o_reg_addr(addr),
    .o_reg_wdata(wdata), .o_reg_wr(wr), .o_reg_rd(rd), .i_reg_rdata(rdata),
    .i_reg_addr_ok(aok), .o_abort_indication(ab), .o_end_of_message(end_of_message),
    .o_link_idle(lidle), .o_busy(busy));
  gmc_host_model u_gmc_host_model (.i_link_clk(link_clk), .i_nrst(nrst),
    .i_tx_line(txl), .i_down(down), .o_fsync(fsync), .o_rx_line(rxl),
    .o_up(up), .o_frames(frames));
  // ==========================================
  // Shared tasks
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic frame(logic [7:0] m, logic mr, logic mx);
    logic [15:0] f0;
    int t;
    @(posedge core_clk);
    #1;
    down = {m, ci_dn, mr, mx};
    f0 = frames;
    t = 0;
    while (frames === f0 && t < 1000) begin
      @(posedge core_clk);
      t++;
    end
    if (t >= 1000) begin
      bad_count++;
      $display("[FAIL] frame tick exp 1 got 0");
      give_verdict();
    end
  endtask
  task automatic idle(int n);
    repeat (n) frame(8'hff, 1'b1, 1'b1);
  endtask
  // Host holds MX low until MR seen high then low, then one gap frame
  task automatic send_byte(logic [7:0] b);
    logic hi;
    hi = 1'b0;
    k = 0;
    do begin
      frame(b, 1'b1, 1'b0);
      k++;
      if (up.mr === 1'b1) hi = 1'b1;
    end while (!(hi && up.mr === 1'b0) && k < 8);
    chk("ack frame", 16'd3, k[15:0]);
    chk("up m", 16'h00ff, {8'h00, up.m});
    frame(8'hff, 1'b1, 1'b1);
  endtask
  task automatic recv_byte();
    k = 0;
    do begin
      frame(8'hff, 1'b1, 1'b1);
      k++;
    end while (up.mx !== 1'b0 && k < 10);
    chk("tx start", 16'h0, {15'h0, up.mx});
    v = up.m;
    k = 0;
    do begin
      frame(8'hff, 1'b0, 1'b1);
      k++;
    end while (up.mx !== 1'b1 && k < 10);
    chk("tx gap", 16'h1, {15'h0, up.mx});
  endtask
  // ==========================================
  // Scenarios
  task automatic t_write();
    send_byte(8'h91);
    send_byte(8'h01);
    send_byte(8'h05);
    send_byte(8'h3c);
    send_byte(8'hc3);
    idle(2);
    chk("eom count", 16'd1, eom_n[15:0]);
    chk("writes", 16'd2, wq.size());
    chk("write 0", 16'h053c, wq[0]);
    chk("write 1", 16'h06c3, wq[1]);
    chk("idle", 16'h1, {15'h0, lidle});
    chk("write busy", 16'h0, {15'h0, busy});
    chk("up ci", 16'h15, {10'h0, up.ci});
    $display("test write done");
  endtask
  task automatic t_badcmd();
    frame(8'h91, 1'b1, 1'b0);
    frame(8'hff, 1'b1, 1'b1);
    idle(3);
    chk("early release", 16'd1, ab_n[15:0]);
    send_byte(8'h91);
    for (int i = 0; i < 4; i++) begin
      frame(8'h02, 1'b1, 1'b0);
      if (i > 0) chk("abort mr", 16'h1, {15'h0, up.mr});
    end
    idle(3);
    chk("abort count", 16'd2, ab_n[15:0]);
    chk("no write", 16'd2, wq.size());
    $display("test bad command done");
  endtask
  task automatic t_ci();
    ci_dn = 6'h0c;
    idle(1);
    ci_dn = 6'h3f;
    idle(3);
    chk("ci single", 16'h3f, {10'h0, ci_st});
    chk("ci pulses", 16'd0, cic_n[15:0]);
    ci_dn = 6'h0c;
    idle(4);
    chk("ci double", 16'h0c, {10'h0, ci_st});
    chk("ci pulse", 16'd1, cic_n[15:0]);
    $display("test ci done");
  endtask
  task automatic t_read();
    send_byte(8'h91);
    send_byte(8'h81);
    send_byte(8'h10);
    idle(1);
    recv_byte();
    chk("echo", 16'h91, {8'h00, v});
    recv_byte();
    chk("rdata", 16'h4a, {8'h00, v});
    frame(8'h00, 1'b1, 1'b1);
    frame(8'h00, 1'b1, 1'b1);
    idle(6);
    chk("collision", 16'd3, ab_n[15:0]);
    chk("reads", 16'd2, rd_n[15:0]);
    chk("busy", 16'h0, {15'h0, busy});
    $display("test read done");
  endtask
  task automatic t_cid();
    send_byte(8'h80);
    send_byte(8'h00);
    idle(1);
    recv_byte();
    chk("id 0", 16'h4a, {8'h00, v});
    recv_byte();
    chk("id 1", 16'ha5, {8'h00, v});
    idle(1);
    chk("id end", 16'hff03, {up.m, 6'h00, up.mr, up.mx});
    idle(3);
    chk("id busy", 16'h0, {15'h0, busy});
    chk("id aborts", 16'd3, ab_n[15:0]);
    repeat (4) frame(8'h88, 1'b1, 1'b0);
    idle(3);
    chk("id a0 b1", 16'd4, ab_n[15:0]);
    $display("test identify done");
  endtask
  initial begin
    nrst = 1'b0;
    ci_dn = 6'h3f;
    down = 16'hffff;
    repeat (10) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    idle(3);
    chk("reset idle", 16'h1, {15'h0, lidle});
    t_write();
    t_badcmd();
    t_ci();
    t_read();
    t_cid();
    give_verdict();
  end
endmodule
bind gmc_monitor gmc_monitor_sva u_gmc_monitor_sva (
  .i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_link_clk(i_link_clk),
  .o_highway_transmit_line(o_highway_transmit_line),
  .o_highway_transmit_oe(o_highway_transmit_oe), .o_ci_state(o_ci_state),
  .o_ci_change(o_ci_change), .o_reg_addr(o_reg_addr), .o_reg_wr(o_reg_wr),
  .o_reg_rd(o_reg_rd), .i_reg_addr_ok(i_reg_addr_ok),
  .o_abort_indication(o_abort_indication),
  .o_end_of_message(o_end_of_message), .o_busy(o_busy));
